/* File: fpg_dev.sv */
// fpg_dev: flash-side program/erase guard with suspend and protection.
// assumes sclk from the host stops outside frames; clk_sys runs free.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - suspend completes within thirty microseconds
// - host waits 100us resume to program suspend
// - host waits 100us resume to erase suspend
// - host allows 100us between resume and suspend
// - page program up to 256 bytes within 2.4ms
// - 32K block erase within 0.8s
// - 64K block erase within 1.2s
// - security program within 2.4ms
// - security erase within 300ms
// - host keeps select idle 2.5ms after power-up
// - array reads erased, status resets to zero
// - reset returns device to standby
// - partial-byte commands are dropped
// - changes need write enable latch set first
// - block protect bits lock a region
// - write-protect low freezes protect bits
// - deep power-down ignores all but release
// - commands touching protected area ignored
module fpg_dev #(
    parameter int PP_CYC   = fpg_pkg::PP_CYC,
    parameter int SPR_CYC  = fpg_pkg::SPR_CYC,
    parameter int BE32_CYC = fpg_pkg::BE32_CYC,
    parameter int BE64_CYC = fpg_pkg::BE64_CYC,
    parameter int SER_CYC  = fpg_pkg::SER_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       ce,
    fpg_link_if.dev         link,
    output logic            busy,
    output logic [7:0]      status
);
    import fpg_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SUSPENDING, ST_SUSPENDED}
        fpg_dev_state_type;

    // ==================================================================
    // link domain: capture the frame
    logic                armed_q;
    logic [11:0]         cnt_q;
    logic [SHIFT_W-1:0]  sh_q;
    logic [16:0]         st_s1_q;
    logic [16:0]         st_s2_q;
    logic                rd_sr_q;
    logic                rd_ar_q;
    logic                oe_q;
    logic                miso_q;
    logic                sr_now;
    logic                ar_now;
    logic [15:0]         word;

    // a new frame restarts the bit count on its first edge
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            armed_q <= 1'b1;
        end else begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(posedge link.sclk) begin
        if (armed_q) begin
            cnt_q <= 12'h001;
            sh_q  <= {{(SHIFT_W-1){1'b0}}, link.mosi};
        end else begin
            if (cnt_q != 12'hFFF) begin
                cnt_q <= cnt_q + 12'h001;
            end
            if (cnt_q < 12'(SHIFT_W)) begin
                sh_q <= {sh_q[SHIFT_W-2:0], link.mosi};
            end
        end
    end

    // status word crosses into the link domain; it is only read back
    logic [7:0] sr0;
    logic [7:0] sr1;
    logic       dp_q;
    always_ff @(posedge link.sclk) begin
        st_s1_q <= {dp_q, sr0, sr1};
        st_s2_q <= st_s1_q;
    end

    assign word   = st_s2_q[15:0];
    assign sr_now = (cnt_q == 12'h008) ? (sh_q[7:0] == OP_RDSR) & ~st_s2_q[16]
                                       : rd_sr_q;
    assign ar_now = (cnt_q == 12'h008) ? (sh_q[7:0] == OP_READ) & ~st_s2_q[16]
                                       : rd_ar_q;

    always_ff @(negedge link.sclk) begin
        rd_sr_q <= sr_now;
        rd_ar_q <= ar_now;
        oe_q    <= (sr_now && cnt_q >= 12'h008) || (ar_now && cnt_q >= 12'h020);
        if (sr_now) begin
            miso_q <= word[~4'(cnt_q - 12'h008)];
        end else begin
            miso_q <= ERASED_BIT;
        end
    end

    assign link.miso    = miso_q;
    // the enable of the previous frame must not leak into the next one
    assign link.miso_oe = oe_q & ~link.cs_n & ~armed_q & (cnt_q >= 12'h008);

    // ==================================================================
    // system domain: frame end detect and decode
    logic              cs_s1_q;
    logic              cs_s2_q;
    logic              cs_s3_q;
    logic              wp_s1_q;
    logic              wp_s2_q;
    logic              arm_s1_q;
    logic              arm_s2_q;
    logic              edges_q;
    logic              frame_end;
    logic [11:0]       nbits;
    logic [8:0]        nbytes;
    logic              whole;
    logic [SHIFT_W-1:0] al;
    logic [7:0]        op;
    logic [22:0]       addr;
    logic [7:0]        d0;
    logic [7:0]        d1;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {cs_s1_q, cs_s2_q, cs_s3_q} <= 3'h7;
            {wp_s1_q, wp_s2_q} <= 2'h3;
            {arm_s1_q, arm_s2_q} <= 2'h3;
        end else if (ce) begin
            arm_s1_q <= armed_q;
            arm_s2_q <= arm_s1_q;
            cs_s1_q <= link.cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            wp_s1_q <= link.wp_n;
            wp_s2_q <= wp_s1_q;
        end
    end

    // a frame counts only once its first sclk edge cleared the armed
    // flag; a select pulse without clocks must not replay the last count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            edges_q <= 1'b0;
        end else if (ce) begin
            if (frame_end) begin
                edges_q <= 1'b0;
            end else if (!cs_s2_q && !arm_s2_q) begin
                edges_q <= 1'b1;
            end
        end
    end

    // link registers are still once select is high and synchronised
    assign frame_end = cs_s2_q & ~cs_s3_q;
    assign nbits     = edges_q ? cnt_q : 12'h000;
    assign nbytes    = nbits[11:3];
    assign whole     = (nbits != 12'h000) && (nbits[2:0] == 3'h0);
    assign al        = (nbits >= 12'(SHIFT_W)) ? sh_q
                     : sh_q << 6'(12'(SHIFT_W) - nbits);
    assign op        = al[47:40];
    assign addr      = al[38:16];
    assign d0        = al[39:32];
    assign d1        = al[31:24];

    // ==================================================================
    // protection decode
    fpg_dev_state_type st_q;
    logic [4:0]  bp_q;
    logic        wel_q;
    logic        srp0_q;
    logic        srp1_q;
    logic        prog_q;
    logic [22:0] psz;
    logic [22:0] lo;
    logic [22:0] hi;
    logic        hit;
    logic        is_arr;
    logic        len_ok;
    logic        cmd;
    logic        go_chg;
    logic        go_sr;

    always_comb begin
        psz = BLK64_SIZE << (bp_q[2:0] - 3'h1);
        lo  = addr;
        hi  = addr;
        if (op == OP_BE32) begin
            lo = addr & ~MASK32K;
            hi = addr | MASK32K;
        end else if (op == OP_BE64) begin
            lo = addr & ~MASK64K;
            hi = addr | MASK64K;
        end
        if (bp_q[2:0] == 3'h0) begin
            hit = 1'b0;
        end else if (bp_q[2:0] == 3'h7) begin
            hit = 1'b1;
        end else if (bp_q[3]) begin
            hit = lo < psz;
        end else begin
            hit = hi >= ARRAY_SIZE - psz;
        end
    end

    assign is_arr = op == OP_PP || op == OP_BE32 || op == OP_BE64;
    assign len_ok = (op == OP_PP || op == OP_SPP)
                  ? nbytes > 9'(HDR_BYTES) && nbytes <= 9'(HDR_BYTES + PAGE_BYTES)
                  : nbytes == 9'(HDR_BYTES);
    // deep power-down lets only the release through
    assign cmd    = frame_end & whole & (~dp_q | op == OP_RDP);
    assign go_chg = cmd & ~dp_q & wel_q & st_q == ST_IDLE & len_ok &
                    (op == OP_SPP || op == OP_SER || is_arr) &
                    ~(is_arr & hit);
    assign go_sr  = cmd & ~dp_q & wel_q & st_q == ST_IDLE & op == OP_WRSR &
                    (nbytes == 9'h2 || nbytes == 9'h3);

    // ==================================================================
    // operation sequencer
    logic [31:0] tmr_q;
    logic [9:0]  slat_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q   <= ST_IDLE;
            tmr_q  <= 32'h0;
            slat_q <= 10'h0;
            prog_q <= 1'b0;
        end else if (ce) begin
            case (st_q)
                ST_IDLE: begin
                    if (go_chg) begin
                        st_q   <= ST_RUN;
                        prog_q <= op == OP_PP || op == OP_SPP;
                        case (op)
                            OP_PP:   tmr_q <= 32'(PP_CYC);
                            OP_SPP:  tmr_q <= 32'(SPR_CYC);
                            OP_BE32: tmr_q <= 32'(BE32_CYC);
                            OP_BE64: tmr_q <= 32'(BE64_CYC);
                            default: tmr_q <= 32'(SER_CYC);
                        endcase
                    end
                end
                ST_RUN: begin
                    if (cmd && op == OP_SUSP) begin
                        st_q   <= ST_SUSPENDING;
                        slat_q <= 10'h0;
                    end else if (tmr_q <= 32'h1) begin
                        st_q  <= ST_IDLE;
                        tmr_q <= 32'h0;
                    end else begin
                        tmr_q <= tmr_q - 32'h1;
                    end
                end
                ST_SUSPENDING: begin
                    if (slat_q == 10'(SUSP_LAT_CYC - 1)) begin
                        st_q <= ST_SUSPENDED;
                    end else begin
                        slat_q <= slat_q + 10'h1;
                    end
                end
                ST_SUSPENDED: begin
                    if (cmd && op == OP_RES) begin
                        st_q <= ST_RUN;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ==================================================================
    // write enable latch, protect bits, deep power-down
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wel_q <= 1'b0;
        end else if (ce) begin
            if (cmd && !dp_q && op == OP_WRITE_ENABLE_CMD) begin
                wel_q <= 1'b1;
            end else if (go_chg || go_sr || (cmd && op == OP_WRDI)) begin
                wel_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bp_q   <= SR_RST[6:2];
            srp0_q <= SR_RST[SR_SRP0];
            srp1_q <= 1'b0;
        end else if (ce) begin
            if (go_sr && wp_s2_q) begin
                bp_q   <= d0[6:2];
                srp0_q <= d0[SR_SRP0];
                if (nbytes == 9'h3) begin
                    srp1_q <= d1[SR1_SRP1];
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dp_q <= 1'b0;
        end else if (ce) begin
            if (cmd && op == OP_RDP) begin
                dp_q <= 1'b0;
            end else if (cmd && op == OP_DP && st_q == ST_IDLE) begin
                dp_q <= 1'b1;
            end
        end
    end

    assign busy   = st_q == ST_RUN || st_q == ST_SUSPENDING;
    assign sr0    = {srp0_q, bp_q, wel_q, busy};
    assign sr1    = {5'h0, st_q == ST_SUSPENDED & ~prog_q,
                     st_q == ST_SUSPENDED & prog_q, srp1_q};
    assign status = sr0;
endmodule
`default_nettype wire

/* File: fpg_pkg.sv */
// fpg_pkg: constants shared by both ends of the serial flash guard link.
// assumes a 20 MHz system clock on both ends.
`default_nettype none
package fpg_pkg;
    // ==================================================================
    // clock and timing
    localparam int CLK_MHZ       = 20;
    localparam int SUSP_LAT_US   = 30;
    localparam int SUSP_LAT_CYC  = SUSP_LAT_US * CLK_MHZ;
    localparam int PP_TIME_US    = 400;
    localparam int PP_CYC        = PP_TIME_US * CLK_MHZ;
    localparam int SPR_TIME_US   = 400;
    localparam int SPR_CYC       = SPR_TIME_US * CLK_MHZ;
    localparam int BE32_TIME_MS  = 120;
    localparam int BE32_CYC      = BE32_TIME_MS * 1000 * CLK_MHZ;
    localparam int BE64_TIME_MS  = 150;
    localparam int BE64_CYC      = BE64_TIME_MS * 1000 * CLK_MHZ;
    localparam int SER_TIME_MS   = 40;
    localparam int SER_CYC       = SER_TIME_MS * 1000 * CLK_MHZ;
    localparam int RES_GAP_US    = 100;
    localparam int RES_GAP_CYC   = RES_GAP_US * CLK_MHZ;
    localparam int PWR_WAIT_US   = 2500;
    localparam int PWR_WAIT_CYC  = PWR_WAIT_US * CLK_MHZ;
    localparam int FRAME_GAP_CYC = 8;
    localparam int SCLK_HALF_CYC = 4;
    // ==================================================================
    // frame layout
    localparam int SHIFT_W    = 48;
    localparam int PAGE_BYTES = 256;
    localparam int HDR_BYTES  = 4;
    // ==================================================================
    // commands
    localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_PP   = 8'h02;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hD8;
    localparam logic [7:0] OP_SPP  = 8'h42;
    localparam logic [7:0] OP_SER  = 8'h44;
    localparam logic [7:0] OP_SUSP = 8'h75;
    localparam logic [7:0] OP_RES  = 8'h7A;
    localparam logic [7:0] OP_DP   = 8'hB9;
    localparam logic [7:0] OP_RDP  = 8'hAB;
    // ==================================================================
    // status layout: byte 0 then byte 1
    localparam int SR_BUSY   = 0;
    localparam int SR_WEL    = 1;
    localparam int SR_BP_LSB = 2;
    localparam int SR_SRP0   = 7;
    localparam int SR1_SRP1  = 0;
    localparam int SR1_SUSP  = 1;
    localparam int SR1_SUSE  = 2;
    localparam logic [7:0] SR_RST      = 8'h00;
    localparam logic       ERASED_BIT  = 1'b1;
    localparam logic [22:0] BLK64_SIZE = 23'h010000;
    localparam logic [22:0] ARRAY_SIZE = 23'h400000;
    localparam logic [22:0] MASK32K    = 23'h007FFF;
    localparam logic [22:0] MASK64K    = 23'h00FFFF;

    function automatic logic fpg_is_change(input logic [7:0] op);
        return op == OP_PP || op == OP_BE32 || op == OP_BE64 ||
               op == OP_SPP || op == OP_SER || op == OP_WRSR;
    endfunction
endpackage
`default_nettype wire

/* File: fpg_link_if.sv */
// fpg_link_if: the serial link between host controller and flash guard.
// assumes the host resolves miso from miso_oe with a pull-up.
`timescale 1ns/1ps
`default_nettype none
interface fpg_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic wp_n;
    modport dev  (input sclk, cs_n, mosi, wp_n, output miso, miso_oe);
    modport host (output sclk, cs_n, mosi, wp_n, input miso, miso_oe);
endinterface
`default_nettype wire

/* File: fpg_host.sv */
// fpg_host: host controller driving the flash link from a command port.
// assumes the device answers on miso under miso_oe; the host reads a released line as high.
`timescale 1ns/1ps
`default_nettype none
module fpg_host #(
    parameter int PWR_CYC = fpg_pkg::PWR_WAIT_CYC,
    parameter int HALF    = fpg_pkg::SCLK_HALF_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    fpg_link_if.host         link,
    input  wire logic        wp_n_req,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [7:0]  cmd_op,
    input  wire logic [23:0] cmd_addr,
    input  wire logic [15:0] cmd_data,
    input  wire logic [2:0]  cmd_len,
    input  wire logic [1:0]  cmd_rd,
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    output logic             pwr_ready
);
    import fpg_pkg::*;

    typedef enum logic [2:0] {H_PWR, H_IDLE, H_WRITE_ENABLE_CMD, H_CMD, H_POLL, H_RSP}
        fpg_host_state_type;

    // ==================================================================
    // frame engine
    logic               go_q;
    logic [SHIFT_W-1:0] go_tx_q;
    logic [6:0]         go_n_q;
    logic [SHIFT_W-1:0] tx_q;
    logic [6:0]         nclk_q;
    logic [6:0]         bit_q;
    logic [7:0]         div_q;
    logic [7:0]         tail_q;
    logic               act_q;
    logic               sclk_q;
    logic               cs_n_q;
    logic               mosi_q;
    logic               done_q;
    logic [15:0]        rx_q;
    logic               miso_s1_q;
    logic               miso_s2_q;
    logic               wp_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            miso_s1_q <= 1'b1;
            miso_s2_q <= 1'b1;
            wp_q      <= 1'b1;
        end else if (ce) begin
            // a released line reads high through its pull-up
            miso_s1_q <= link.miso | ~link.miso_oe;
            miso_s2_q <= miso_s1_q;
            wp_q      <= wp_n_req;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
            act_q  <= 1'b0;
            done_q <= 1'b0;
            tail_q <= 8'h0;
            div_q  <= 8'h0;
            bit_q  <= 7'h0;
            nclk_q <= 7'h0;
            tx_q   <= '0;
            rx_q   <= 16'h0;
        end else if (ce) begin
            done_q <= 1'b0;
            if (go_q) begin
                tx_q   <= go_tx_q << 1;
                mosi_q <= go_tx_q[SHIFT_W-1];
                nclk_q <= go_n_q;
                bit_q  <= 7'h0;
                div_q  <= 8'h0;
                act_q  <= 1'b1;
                cs_n_q <= 1'b0;
            end else if (act_q) begin
                if (div_q == 8'(HALF - 1)) begin
                    div_q <= 8'h0;
                    if (bit_q == nclk_q) begin
                        cs_n_q <= 1'b1;
                        act_q  <= 1'b0;
                        tail_q <= 8'(FRAME_GAP_CYC);
                    end else if (!sclk_q) begin
                        sclk_q <= 1'b1;
                        rx_q   <= {rx_q[14:0], miso_s2_q};
                    end else begin
                        sclk_q <= 1'b0;
                        bit_q  <= bit_q + 7'h1;
                        mosi_q <= tx_q[SHIFT_W-1];
                        tx_q   <= tx_q << 1;
                    end
                end else begin
                    div_q <= div_q + 8'h1;
                end
            end else if (tail_q != 8'h0) begin
                tail_q <= tail_q - 8'h1;
                done_q <= tail_q == 8'h1;
            end
        end
    end

    assign link.sclk = sclk_q;
    assign link.cs_n = cs_n_q;
    assign link.mosi = mosi_q;
    assign link.wp_n = wp_q;

    // ==================================================================
    // command sequencer
    fpg_host_state_type st_q;
    logic [31:0]        pwr_q;
    logic [11:0]        gap_q;
    logic [7:0]         op_q;
    logic [SHIFT_W-1:0] cf_q;
    logic [6:0]         cn_q;
    logic [SHIFT_W-1:0] cmd_frame;
    logic [6:0]         cmd_n;

    assign cmd_frame = {cmd_op, cmd_addr, cmd_data};
    assign cmd_n     = 7'({cmd_len, 3'h0}) + 7'({cmd_rd, 3'h0});
    // suspend waits out the gap after the last resume
    assign cmd_ready = st_q == H_IDLE &&
                       !(cmd_op == OP_SUSP && gap_q < 12'(RES_GAP_CYC));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gap_q <= 12'(RES_GAP_CYC);
        end else if (ce) begin
            if (st_q == H_CMD && done_q && op_q == OP_RES) begin
                gap_q <= 12'h0;
            end else if (gap_q < 12'(RES_GAP_CYC)) begin
                gap_q <= gap_q + 12'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q    <= H_PWR;
            pwr_q   <= 32'h0;
            go_q    <= 1'b0;
            go_tx_q <= '0;
            go_n_q  <= 7'h0;
            op_q    <= 8'h0;
            cf_q    <= '0;
            cn_q    <= 7'h0;
        end else if (ce) begin
            go_q <= 1'b0;
            case (st_q)
                H_PWR: begin
                    if (pwr_q == 32'(PWR_CYC - 1)) begin
                        st_q <= H_IDLE;
                    end else begin
                        pwr_q <= pwr_q + 32'h1;
                    end
                end
                H_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        op_q <= cmd_op;
                        cf_q <= cmd_frame;
                        cn_q <= cmd_n;
                        go_q <= 1'b1;
                        if (fpg_is_change(cmd_op)) begin
                            go_tx_q <= {OP_WRITE_ENABLE_CMD, 40'h0};
                            go_n_q  <= 7'h08;
                            st_q    <= H_WRITE_ENABLE_CMD;
                        end else begin
                            go_tx_q <= cmd_frame;
                            go_n_q  <= cmd_n;
                            st_q    <= H_CMD;
                        end
                    end
                end
                H_WRITE_ENABLE_CMD: begin
                    if (done_q) begin
                        go_tx_q <= cf_q;
                        go_n_q  <= cn_q;
                        go_q    <= 1'b1;
                        st_q    <= H_CMD;
                    end
                end
                H_CMD, H_POLL: begin
                    if (done_q) begin
                        if (fpg_is_change(op_q) &&
                            (st_q == H_CMD || rx_q[SR_BUSY])) begin
                            go_tx_q <= {OP_RDSR, 40'h0};
                            go_n_q  <= 7'h10;
                            go_q    <= 1'b1;
                            st_q    <= H_POLL;
                        end else begin
                            st_q <= H_RSP;
                        end
                    end
                end
                H_RSP: st_q <= H_IDLE;
                default: st_q <= H_IDLE;
            endcase
        end
    end

    assign rsp_valid = st_q == H_RSP;
    assign rsp_data  = rx_q;
    assign pwr_ready = st_q != H_PWR;
endmodule
`default_nettype wire

/* File: fpg_asserts.sv */
// fpg_asserts: link checks for the guard pair.
// assumes sclk is a clk_sys register of the host.
`timescale 1ns/1ps
`default_nettype none
module fpg_asserts
    import fpg_pkg::*;
#(parameter int PWR_CYC = PWR_WAIT_CYC) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_oe
);
    // ==========
    // helpers
    logic [15:0] up_q;
    logic [2:0]  bit_q;
    logic [3:0]  n_q;
    logic [7:0]  op_q;
    logic [11:0] gap_q;
    always_ff @(posedge clk_sys)
        up_q <= rst ? 16'h0 : up_q + 16'(up_q < PWR_CYC);
    always_ff @(posedge clk_sys) begin
        bit_q <= cs_n ? 3'h0 : bit_q + 3'($rose(sclk));
        n_q <= cs_n ? 4'h0 : n_q + 4'($rose(sclk) && n_q < 4'h8);
        if ($rose(sclk) && n_q < 4'h8) op_q <= {op_q[6:0], mosi};
    end
    always_ff @(posedge clk_sys)
        if (rst) gap_q <= 12'hFFF;
        else if ($rose(cs_n) && op_q == OP_RES) gap_q <= 12'h0;
        else gap_q <= gap_q + 12'(gap_q != 12'hFFF);
    sequence s_idle5;
        cs_n [*5];
    endsequence
    // ==========
    // assertions
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_pwr_wait_idle: assert property (up_q < PWR_CYC |-> cs_n)
        else $error("select too early");
    a_frame_whole: assert property ($rose(cs_n) |-> bit_q == 3'h0)
        else $error("partial byte");
    a_susp_gap: assert property ($rose(cs_n) && op_q == OP_SUSP
        |-> gap_q >= 12'h7D0) else $error("suspend too soon");
    a_deselect_gap: assert property ($rose(cs_n) |-> s_idle5)
        else $error("short deselect");
    a_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("sclk outside frame");
    a_oe_selected: assert property (miso_oe |-> !cs_n && n_q == 4'h8)
        else $error("miso driven idle");
    a_sclk_high: assert property ($rose(sclk) |=> sclk [*3])
        else $error("sclk high short");
    a_lead_low: assert property ($fell(cs_n) |-> !sclk [*4])
        else $error("sclk lead short");
endmodule
`default_nettype wire

/* File: tb_top.sv */
// tb_top: host and guard joined by the link, driven from the command port.
// assumes short device durations set below.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fpg_pkg::*;
    logic        clk_sys = 1'b0, rst = 1'b1, wp_n_req = 1'b1, ce = 1'b1;
    logic        cmd_valid = 1'b0, cmd_ready, rsp_valid, pwr_ready, busy;
    logic [7:0]  cmd_op = 8'h0, status;
    logic [23:0] cmd_addr = 24'h0;
    logic [2:0]  cmd_len = 3'h1;
    logic [1:0]  cmd_rd = 2'h0;
    logic [15:0] rsp_data, cmd_data = 16'hA55A;
    int          num_errors = 0, total_checks = 0, busy_cyc = 0, b;
    fpg_link_if link_if ();
    fpg_dev #(.PP_CYC(120), .SPR_CYC(130), .BE32_CYC(140), .BE64_CYC(150),
        .SER_CYC(160)) fpg_dev_inst (.clk_sys, .rst, .ce,
        .link(link_if.dev), .busy, .status);
    fpg_host fpg_host_inst (.clk_sys, .rst, .ce,
        .link(link_if.host), .wp_n_req, .cmd_valid, .cmd_ready, .cmd_op,
        .cmd_addr, .cmd_data, .cmd_len, .cmd_rd, .rsp_valid,
        .rsp_data, .pwr_ready);
    fpg_asserts fpg_asserts_inst (.clk_sys, .rst,
        .sclk(link_if.sclk), .cs_n(link_if.cs_n), .mosi(link_if.mosi),
        .miso_oe(link_if.miso_oe));
    initial forever #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) busy_cyc <= busy_cyc + int'(busy === 1'b1);
    task automatic wrap_up;
        if (num_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] a,
        input logic [2:0] n, input logic [1:0] r);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_len <= n;
        cmd_rd <= r;
        cmd_valid <= 1'b1;
        do @(posedge clk_sys); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        do @(posedge clk_sys); while (rsp_valid !== 1'b1);
    endtask
    task automatic t_start;
        cmd(OP_RDSR, 24'h0, 3'h1, 2'h2);
        chk(rsp_data, 16'h0000);
        chk({15'h0, pwr_ready}, 16'h0001);
        cmd(OP_READ, 24'h0, 3'h4, 2'h2);
        chk(rsp_data, 16'hFFFF);
    endtask
    task automatic t_ops;
        logic [7:0] ops [5] = '{OP_PP, OP_SPP, OP_BE32, OP_BE64, OP_SER};
        foreach (ops[i]) begin
            b = busy_cyc;
            cmd(ops[i], 24'h0, i < 2 ? 3'h6 : 3'h4, 2'h0);
            chk(16'(busy_cyc - b), 16'(120 + 10 * i));
            chk({8'h0, status}, 16'h0000);
        end
    endtask
    task automatic t_prot;
        cmd(OP_WRSR, 24'h1C0000, 3'h2, 2'h0);
        chk({8'h0, status}, 16'h001C);
        b = busy_cyc;
        cmd(OP_PP, 24'h0, 3'h6, 2'h0);
        chk(16'(busy_cyc - b), 16'h0000);
        chk({8'h0, status}, 16'h001E);
        wp_n_req <= 1'b0;
        cmd(OP_WRSR, 24'h0, 3'h2, 2'h0);
        chk({8'h0, status}, 16'h001C);
        wp_n_req <= 1'b1;
        cmd(OP_WRSR, 24'h0, 3'h2, 2'h0);
        chk({8'h0, status}, 16'h0000);
    endtask
    task automatic t_deep;
        cmd(OP_DP, 24'h0, 3'h1, 2'h0);
        cmd(OP_WRITE_ENABLE_CMD, 24'h0, 3'h1, 2'h0);
        chk({8'h0, status}, 16'h0000);
        cmd(OP_RDP, 24'h0, 3'h1, 2'h0);
        cmd(OP_WRITE_ENABLE_CMD, 24'h0, 3'h1, 2'h0);
        chk({8'h0, status}, 16'h0002);
        cmd(OP_WRDI, 24'h0, 3'h1, 2'h0);
        chk({8'h0, status}, 16'h0000);
    endtask
    task automatic t_susp;
        cmd(OP_RES, 24'h0, 3'h1, 2'h0);
        cmd(OP_SUSP, 24'h0, 3'h1, 2'h0);
        chk({8'h0, status}, 16'h0000);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        t_start;
        t_ops;
        t_prot;
        t_deep;
        t_susp;
        wrap_up;
    end
    initial begin
        #4000000;
        num_errors++;
        wrap_up;
    end
endmodule
`default_nettype wire
